//--- logic/emcy_pkg.sv
`default_nettype none
package emcy_pkg;
	// Object dictionary indexes and sub-indexes
	localparam logic [15:0] IDX_FAULT_BITS    = 16'h1002;
	localparam logic [15:0] IDX_ERROR_HISTORY = 16'h1003;
	localparam logic [15:0] IDX_EMCY_ID       = 16'h1014;
	localparam logic [15:0] IDX_EMCY_INHIBIT  = 16'h1015;
	localparam logic [15:0] IDX_RANGE         = 16'h4000;
	localparam logic [15:0] IDX_AXIS_MODE     = 16'h4001;
	localparam logic [7:0]  SUB_ZERO          = 8'h00;
	localparam logic [7:0]  SUB_THR_X         = 8'h01;
	localparam logic [7:0]  SUB_THR_Y         = 8'h02;
	localparam logic [7:0]  SUB_RANGE_EN      = 8'h03;
	localparam logic [7:0]  SUB_HIST_LAST     = 8'h05;
	localparam int          HIST_DEPTH        = 5;

	// Fault register bit positions
	localparam int FB_GUARD    = 15;
	localparam int FB_OVERRUN  = 10;
	localparam int FB_BUSOFF   = 9;
	localparam int FB_WARN     = 8;
	localparam int FB_SELFTEST = 7;
	localparam int FB_CRC      = 4;
	localparam int FB_TEMP     = 3;
	localparam int FB_AXIS_Y   = 2;
	localparam int FB_AXIS_X   = 1;

	// Error summary byte bit positions
	localparam int ES_ANY     = 0;
	localparam int ES_TEMP    = 3;
	localparam int ES_COMM    = 4;
	localparam int ES_PROFILE = 5;
	localparam int ES_HW      = 7;

	// Error codes
	localparam logic [15:0] EC_RESET   = 16'h0000;
	localparam logic [15:0] EC_GENERIC = 16'h1030;
	localparam logic [15:0] EC_TEMP    = 16'h4200;
	localparam logic [15:0] EC_HW      = 16'h5000;
	localparam logic [15:0] EC_AXIS_X  = 16'h5010;
	localparam logic [15:0] EC_AXIS_Y  = 16'h5020;
	localparam logic [15:0] EC_OVERRUN = 16'h8110;
	localparam logic [15:0] EC_WARN    = 16'h8120;
	localparam logic [15:0] EC_GUARD   = 16'h8130;
	localparam logic [15:0] EC_BUSOFF_RECOVER = 16'h8140;

	// Frame identifiers and command bytes
	localparam logic [10:0] COB_SDO_RX = 11'h600;
	localparam logic [10:0] COB_SDO_TX = 11'h580;
	localparam logic [7:0]  CMD_WRITE     = 8'h22;
	localparam logic [7:0]  CMD_WRITE_ACK = 8'h60;
	localparam logic [7:0]  CMD_READ      = 8'h40;
	localparam logic [7:0]  CMD_READ_ACK  = 8'h43;
	localparam logic [7:0]  CMD_ABORT     = 8'h80;
	localparam logic [31:0] ABORT_COMMAND = 32'h0504_0001;
	localparam logic [31:0] ABORT_RO      = 32'h0601_0002;
	localparam logic [31:0] ABORT_NO_OBJ  = 32'h0602_0000;
	localparam logic [31:0] ABORT_NO_SUB  = 32'h0609_0011;

	// Reset values
	localparam logic [31:0] EMCY_ID_RST  = 32'h0000_0080;
	localparam logic [15:0] INHIBIT_RST  = 16'h0000;
	localparam logic [15:0] THR_RST      = 16'h0000;
	localparam logic [7:0]  RANGE_EN_RST = 8'h00;
	localparam logic [7:0]  RANGE_EN_ON  = 8'h01;
	localparam logic [7:0]  MODE_RST     = 8'h00;
	localparam logic [7:0]  MODE_TWO_AXIS = 8'h00;

	// Timing
	localparam int CLK_PERIOD_NS       = 100;
	localparam int INHIBIT_UNIT_NS     = 100000;
	localparam int INHIBIT_UNIT_CYCLES = INHIBIT_UNIT_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic [10:0] id;
		logic [63:0] data;
	} can_frame_t;

	typedef struct packed {
		logic guard_err;
		logic rx_overrun;
		logic bus_off;
		logic warn_limit;
		logic selftest_err;
		logic crc_err;
		logic temp_err;
	} fault_in_t;
endpackage
`default_nettype wire

//--- logic/emergency_error_reporting.sv
// Operation
// [R1] 32-bit fault register mirrors active errors; bits 31..16 read zero.
// [R2] Bits 15..8: guarding, receive overrun, bus-off, warning limit.
// [R3] Bits 7..0: self-test, CRC, temperature, Y axis, X axis.
// [R4] Inclination beyond configured X or Y threshold sets bit 1 or 2.
// [R5] Low 16 fault bits travel in every emergency frame.
// [R6] History keeps count plus five entries, newest at sub-index 1.
// [R7] New error enters at sub-index 1, older shift down, oldest dropped.
// [R8] History entry: fault bits 15..0 above, error code below.
// [R9] Device error codes 0000h,1030h,4200h,5000h,5010h,5020h.
// [R10] Communication error codes 8110h,8120h,8130h,8140h.
// [R11] Any new error triggers an emergency frame with priority.
// [R12] Clearing of all errors sends an error reset emergency frame; when bus-off is the last to clear, code 8140h is sent instead.
// [R13] Emergency identifier is configurable base 80h plus node identifier.
// [R14] Payload: code, summary, comm field, device field, three zero bytes.
// [R15] Emergency frames spaced at least inhibit time times 100 us.
// [R16] Write 22h on 600h+node confirmed by 60h on 580h+node, echoing.
// [R17] Axis mode 00h at 4001h selects two-axis measurement.
// [R18] Writing 01h to 4000h sub 03h enables user range checking.
// [R19] Master scales thresholds by current resolution before writing.
// [R20] Error code sent low byte first in byte 0.
// [R21] Summary bit 0 set whenever any error is active.
// [R22] Inhibit value zero imposes no spacing.
`timescale 1ns/1ps
`default_nettype none
module emergency_error_reporting
	import emcy_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [6:0]  i_node_identifier,
	input  wire fault_in_t   i_faults,
	input  wire logic [15:0] i_angle_x,
	input  wire logic [15:0] i_angle_y,
	input  wire logic        i_rx_valid,
	input  wire can_frame_t  i_rx_frame,
	input  wire logic        i_tx_ready,
	output logic             o_tx_valid,
	output can_frame_t       o_tx_frame
);

	logic [31:0] fault_bits;
	logic [31:0] fault_prev;
	logic [31:0] next_fault;
	logic [31:0] error_history [HIST_DEPTH];
	logic [2:0]  hist_count;
	logic [31:0] emergency_identifier;
	logic [15:0] emergency_inhibit_time;
	logic [15:0] thr_x;
	logic [15:0] thr_y;
	logic [7:0]  range_en;
	logic [7:0]  axis_mode;
	logic [16:0] mag_x;
	logic [16:0] mag_y;
	logic        over_x;
	logic        over_y;
	logic [7:0]  summary;
	logic [31:0] rise;
	logic        busoff_fall;
	logic        evt_err;
	logic        evt_reset;
	logic [15:0] evt_code;
	logic        emcy_pend;
	logic [15:0] emcy_code;
	logic [15:0] inh_left;
	logic [9:0]  inh_sub;
	logic        emcy_load;
	logic        sdo_load;
	logic        tx_is_emcy;
	logic        sdo_pend;
	logic [63:0] sdo_resp;
	logic        sdo_req;
	logic [7:0]  rq_cmd;
	logic [15:0] rq_idx;
	logic [7:0]  rq_sub;
	logic [31:0] rq_val;
	logic        od_ok;
	logic        od_wr_ok;
	logic [31:0] od_abort;
	logic [31:0] rd_val;
	logic [2:0]  hist_sel;

	////////////////////////////////////////////////////////////////////////////
	// Fault register

	// Magnitudes carry a 17th bit so that -32768 does not wrap
	assign mag_x  = i_angle_x[15] ? 17'(-{1'b1, i_angle_x}) : {1'b0, i_angle_x};
	assign mag_y  = i_angle_y[15] ? 17'(-{1'b1, i_angle_y}) : {1'b0, i_angle_y};
	assign over_x = (range_en == RANGE_EN_ON) && (mag_x > {1'b0, thr_x}); // [R18]
	// Single-axis mode leaves the Y path unchecked
	assign over_y = (range_en == RANGE_EN_ON) && (axis_mode == MODE_TWO_AXIS)
		&& (mag_y > {1'b0, thr_y}); // [R17]

	always_comb
	begin
		next_fault              = 32'h0000_0000; // [R1]
		next_fault[FB_GUARD]    = i_faults.guard_err; // [R2]
		next_fault[FB_OVERRUN]  = i_faults.rx_overrun;
		next_fault[FB_BUSOFF]   = i_faults.bus_off;
		next_fault[FB_WARN]     = i_faults.warn_limit;
		next_fault[FB_SELFTEST] = i_faults.selftest_err; // [R3]
		next_fault[FB_CRC]      = i_faults.crc_err;
		next_fault[FB_TEMP]     = i_faults.temp_err;
		next_fault[FB_AXIS_Y]   = over_y; // [R4]
		next_fault[FB_AXIS_X]   = over_x; // [R4]
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			fault_bits <= 32'h0000_0000;
			fault_prev <= 32'h0000_0000;
		end
		else
		begin
			fault_bits <= next_fault;
			fault_prev <= fault_bits;
		end
	end

	always_comb
	begin
		summary             = 8'h00;
		summary[ES_ANY]     = |fault_bits[15:0]; // [R21]
		summary[ES_TEMP]    = fault_bits[FB_TEMP];
		summary[ES_COMM]    = |fault_bits[15:8];
		summary[ES_PROFILE] = fault_bits[FB_AXIS_X] | fault_bits[FB_AXIS_Y];
		summary[ES_HW]      = fault_bits[FB_SELFTEST] | fault_bits[FB_CRC];
	end

	////////////////////////////////////////////////////////////////////////////
	// Error events and codes

	assign rise        = fault_bits & ~fault_prev;
	assign busoff_fall = fault_prev[FB_BUSOFF] & ~fault_bits[FB_BUSOFF];
	assign evt_err     = (|rise) | busoff_fall;
	assign evt_reset   = (fault_prev != 32'h0) && (fault_bits == 32'h0) && !busoff_fall;

	// Most severe newly raised fault names the event
	always_comb
	begin
		if (rise[FB_SELFTEST] || rise[FB_CRC])
			evt_code = EC_HW; // [R9]
		else if (rise[FB_TEMP])
			evt_code = EC_TEMP;
		else if (rise[FB_AXIS_X])
			evt_code = EC_AXIS_X;
		else if (rise[FB_AXIS_Y])
			evt_code = EC_AXIS_Y;
		else if (rise[FB_GUARD])
			evt_code = EC_GUARD; // [R10]
		else if (rise[FB_OVERRUN])
			evt_code = EC_OVERRUN;
		else if (rise[FB_WARN])
			evt_code = EC_WARN;
		else if (busoff_fall)
			evt_code = EC_BUSOFF_RECOVER;
		else
			evt_code = EC_GENERIC;
	end

	////////////////////////////////////////////////////////////////////////////
	// Error history

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			hist_count <= 3'h0;
		else if (evt_err && hist_count < 3'(HIST_DEPTH))
			hist_count <= hist_count + 3'h1; // [R6]
	end

	for (genvar i = 0; i < HIST_DEPTH; i++)
	begin : g_hist
		always_ff @(posedge i_clk or negedge i_rst_n)
		begin
			if (!i_rst_n)
				error_history[i] <= 32'h0000_0000;
			else if (evt_err)
			begin
				if (i == 0)
					error_history[i] <= {fault_bits[15:0], evt_code}; // [R8]
				else
					error_history[i] <= error_history[(i == 0) ? 0 : i - 1]; // [R7]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Emergency scheduling and inhibit

	// A new event in the load cycle stays pending: set wins over clear
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			emcy_pend <= 1'b0;
			emcy_code <= EC_RESET;
		end
		else if (evt_err || evt_reset)
		begin
			emcy_pend <= 1'b1; // [R11] [R12]
			emcy_code <= evt_err ? evt_code : EC_RESET;
		end
		else if (emcy_load)
			emcy_pend <= 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			inh_left <= 16'h0000;
			inh_sub  <= 10'h000;
		end
		else if (o_tx_valid && i_tx_ready && tx_is_emcy)
		begin
			inh_left <= emergency_inhibit_time; // [R15]
			inh_sub  <= 10'h000;
		end
		else if (inh_left != 16'h0000)
		begin
			if (inh_sub == 10'(INHIBIT_UNIT_CYCLES - 1))
			begin
				inh_sub  <= 10'h000;
				inh_left <= inh_left - 16'h0001;
			end
			else
				inh_sub <= inh_sub + 10'h001;
		end
	end

	// Emergency frames take precedence over confirmations
	assign emcy_load = !o_tx_valid && emcy_pend && (inh_left == 16'h0000); // [R15] [R22]
	assign sdo_load  = !o_tx_valid && !emcy_load && sdo_pend;

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_tx_valid <= 1'b0;
			tx_is_emcy <= 1'b0;
			o_tx_frame <= '0;
		end
		else if (emcy_load)
		begin
			o_tx_valid      <= 1'b1;
			tx_is_emcy      <= 1'b1;
			o_tx_frame.id   <= 11'(emergency_identifier[10:0] + {4'h0, i_node_identifier}); // [R13]
			// Low byte of code sits in byte 0; comm field in byte 3, device field in byte 4
			o_tx_frame.data <= {24'h000000, fault_bits[7:0], fault_bits[15:8], summary,
				emcy_code}; // [R5] [R14] [R20]
		end
		else if (sdo_load)
		begin
			o_tx_valid      <= 1'b1;
			tx_is_emcy      <= 1'b0;
			o_tx_frame.id   <= 11'(COB_SDO_TX + {4'h0, i_node_identifier}); // [R16]
			o_tx_frame.data <= sdo_resp;
		end
		else if (i_tx_ready)
			o_tx_valid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration exchange

	assign rq_cmd   = i_rx_frame.data[7:0];
	assign rq_idx   = i_rx_frame.data[23:8];
	assign rq_sub   = i_rx_frame.data[31:24];
	assign rq_val   = i_rx_frame.data[63:32];
	// A request arriving while a confirmation is still queued is dropped
	assign sdo_req  = i_rx_valid && !sdo_pend
		&& (i_rx_frame.id == 11'(COB_SDO_RX + {4'h0, i_node_identifier}));
	assign hist_sel = 3'(rq_sub - 8'h01);

	always_comb
	begin
		rd_val   = 32'h0000_0000;
		od_abort = 32'h0000_0000;
		od_wr_ok = 1'b0;
		unique case (rq_idx)
			IDX_FAULT_BITS:
				rd_val = fault_bits;
			IDX_ERROR_HISTORY:
				if (rq_sub == SUB_ZERO)
					rd_val = {29'h0, hist_count};
				else if (rq_sub <= SUB_HIST_LAST)
					rd_val = error_history[hist_sel]; // [R6]
				else
					od_abort = ABORT_NO_SUB;
			IDX_EMCY_ID:
			begin
				rd_val   = emergency_identifier;
				od_wr_ok = 1'b1;
			end
			IDX_EMCY_INHIBIT:
			begin
				rd_val   = {16'h0, emergency_inhibit_time};
				od_wr_ok = 1'b1;
			end
			IDX_RANGE:
			begin
				od_wr_ok = 1'b1;
				if (rq_sub == SUB_THR_X)
					rd_val = {16'h0, thr_x};
				else if (rq_sub == SUB_THR_Y)
					rd_val = {16'h0, thr_y};
				else if (rq_sub == SUB_RANGE_EN)
					rd_val = {24'h0, range_en};
				else
					od_abort = ABORT_NO_SUB;
			end
			IDX_AXIS_MODE:
			begin
				rd_val   = {24'h0, axis_mode};
				od_wr_ok = 1'b1;
			end
			default:
				od_abort = ABORT_NO_OBJ;
		endcase
		if (od_abort == 32'h0 && rq_idx != IDX_ERROR_HISTORY && rq_idx != IDX_RANGE
			&& rq_sub != SUB_ZERO)
			od_abort = ABORT_NO_SUB;
		if (od_abort == 32'h0 && rq_cmd == CMD_WRITE && !od_wr_ok)
			od_abort = ABORT_RO;
		if (rq_cmd != CMD_WRITE && rq_cmd != CMD_READ)
			od_abort = ABORT_COMMAND;
	end

	assign od_ok = (od_abort == 32'h0000_0000);

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sdo_pend <= 1'b0;
			sdo_resp <= 64'h0;
		end
		else if (sdo_req)
		begin
			sdo_pend <= 1'b1;
			if (!od_ok)
				sdo_resp <= {od_abort, rq_sub, rq_idx, CMD_ABORT};
			else if (rq_cmd == CMD_WRITE)
				sdo_resp <= {32'h0, rq_sub, rq_idx, CMD_WRITE_ACK}; // [R16]
			else
				sdo_resp <= {rd_val, rq_sub, rq_idx, CMD_READ_ACK};
		end
		else if (sdo_load)
			sdo_pend <= 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			emergency_identifier   <= EMCY_ID_RST;
			emergency_inhibit_time <= INHIBIT_RST;
			thr_x                  <= THR_RST;
			thr_y                  <= THR_RST;
			range_en               <= RANGE_EN_RST;
			axis_mode              <= MODE_RST;
		end
		else if (sdo_req && od_ok && rq_cmd == CMD_WRITE)
		begin
			if (rq_idx == IDX_EMCY_ID)
				emergency_identifier <= rq_val; // [R13]
			if (rq_idx == IDX_EMCY_INHIBIT)
				emergency_inhibit_time <= rq_val[15:0];
			if (rq_idx == IDX_RANGE && rq_sub == SUB_THR_X)
				thr_x <= rq_val[15:0];
			if (rq_idx == IDX_RANGE && rq_sub == SUB_THR_Y)
				thr_y <= rq_val[15:0];
			if (rq_idx == IDX_RANGE && rq_sub == SUB_RANGE_EN)
				range_en <= rq_val[7:0]; // [R18]
			if (rq_idx == IDX_AXIS_MODE)
				axis_mode <= rq_val[7:0]; // [R17]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	logic [31:0] gap_cnt;
	logic [31:0] gap_need;
	logic        emcy_seen;

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			gap_cnt   <= 32'h0;
			gap_need  <= 32'h0;
			emcy_seen <= 1'b0;
		end
		else if (o_tx_valid && i_tx_ready && tx_is_emcy)
		begin
			gap_cnt   <= 32'h0;
			gap_need  <= 32'(emergency_inhibit_time) * 32'(INHIBIT_UNIT_CYCLES);
			emcy_seen <= 1'b1;
		end
		else if (gap_cnt != 32'hffff_ffff)
			gap_cnt <= gap_cnt + 32'h1;
	end

	sequence s_emcy_queued;
		emcy_pend ##1 (o_tx_valid && tx_is_emcy);
	endsequence

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	chk_fault_unused: assert property (fault_bits[31:16] == 16'h0 && fault_bits[14:11] == 4'h0) // [R1]
		else $error("unused fault bits set");
	chk_comm_field: assert property ( // [R2]
		##1 fault_bits[FB_GUARD] == $past(i_faults.guard_err)
		&& fault_bits[FB_BUSOFF] == $past(i_faults.bus_off))
		else $error("communication field does not follow inputs");
	chk_device_field: assert property ( // [R3]
		##1 fault_bits[FB_SELFTEST] == $past(i_faults.selftest_err)
		&& fault_bits[FB_TEMP] == $past(i_faults.temp_err))
		else $error("device field does not follow inputs");
	chk_axis_threshold: assert property (over_x |=> fault_bits[FB_AXIS_X]) // [R4]
		else $error("X threshold crossing not flagged");
	chk_history_shift: assert property (evt_err |=> // [R7]
		error_history[1] == $past(error_history[0])
		&& error_history[0][31:16] == $past(fault_bits[15:0]))
		else $error("history did not shift");
	chk_history_count: assert property (hist_count <= 3'(HIST_DEPTH)) // [R6]
		else $error("history count beyond depth");
	chk_emcy_trigger: assert property (evt_err |=> emcy_pend && emcy_code == $past(evt_code)) // [R11]
		else $error("error event not queued");
	chk_error_reset: assert property (evt_reset |=> emcy_pend && emcy_code == EC_RESET) // [R12]
		else $error("error reset not queued");
	chk_emcy_frame: assert property (emcy_load |=> // [R14]
		o_tx_frame.data[63:40] == 24'h0
		&& o_tx_frame.data[15:0] == $past(emcy_code)
		&& o_tx_frame.data[39:24] == {$past(fault_bits[7:0]), $past(fault_bits[15:8])}
		&& o_tx_frame.id
		== 11'($past(emergency_identifier[10:0]) + {4'h0, $past(i_node_identifier)}))
		else $error("emergency frame layout wrong");
	chk_inhibit_gap: assert property (emcy_load && emcy_seen |-> gap_cnt >= gap_need) // [R15]
		else $error("emergency frames too close");
	chk_emcy_sent: assert property (emcy_pend && !o_tx_valid && inh_left == 16'h0 // [R22]
		|-> s_emcy_queued)
		else $error("pending emergency not sent");
	chk_sdo_confirm: assert property (sdo_req && od_ok && rq_cmd == CMD_WRITE // [R16]
		|=> sdo_pend && sdo_resp[7:0] == CMD_WRITE_ACK
		&& sdo_resp[31:8] == $past(i_rx_frame.data[31:8]))
		else $error("write confirmation wrong");

endmodule
`default_nettype wire

//--- tb/can_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module can_master_model
	import emcy_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_tx_valid,
	input  wire can_frame_t i_tx_frame,
	output logic            o_tx_ready,
	output logic            o_rx_valid,
	output can_frame_t      o_rx_frame
);
	logic        stall;
	int unsigned cycle;
	int unsigned t_prev;
	int unsigned t_last;
	can_frame_t  got[$];

	initial
	begin
		stall = 1'b0;
		cycle = 0;
		t_prev = 0;
		t_last = 0;
		o_rx_valid = 1'b0;
		o_rx_frame = '0;
	end

	// Stalling toggles ready so frames must wait a cycle now and then
	always_ff @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n)
			o_tx_ready <= 1'b0;
		else
			o_tx_ready <= stall ? ~o_tx_ready : 1'b1;

	// Only emergency frames are timed, so replies in between do not hide the gap
	always @(posedge i_clk)
	begin
		cycle <= cycle + 1;
		if (i_tx_valid && o_tx_ready)
		begin
			got.push_back(i_tx_frame);
			if (i_tx_frame.id < COB_SDO_TX)
			begin
				t_prev <= t_last;
				t_last <= cycle;
			end
		end
	end

	// Released lines show the inverse so a stale value cannot pass as fresh
	task automatic send(input can_frame_t f);
		@(posedge i_clk);
		o_rx_valid <= 1'b1;
		o_rx_frame <= f;
		@(posedge i_clk);
		o_rx_valid <= 1'b0;
		o_rx_frame <= ~f;
	endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import emcy_pkg::*;
;
	localparam logic [6:0] NODE = 7'h0a;
	logic        i_clk;
	logic        i_rst_n;
	fault_in_t   i_faults;
	logic [15:0] i_angle_x;
	logic [15:0] i_angle_y;
	logic        rx_valid;
	can_frame_t  rx_frame;
	logic        tx_ready;
	logic        tx_valid;
	can_frame_t  tx_frame;
	int          fails;
	int          checks;
	logic [10:0] emcy_base;
	logic [31:0] hist[$];
	can_frame_t  fr;

	emergency_error_reporting dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_node_identifier(NODE), .i_faults(i_faults), .i_angle_x(i_angle_x),
		.i_angle_y(i_angle_y), .i_rx_valid(rx_valid), .i_rx_frame(rx_frame),
		.i_tx_ready(tx_ready), .o_tx_valid(tx_valid), .o_tx_frame(tx_frame));
	can_master_model m (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx_valid(tx_valid),
		.i_tx_frame(tx_frame), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid),
		.o_rx_frame(rx_frame));

	always #50 i_clk = ~i_clk;

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Bound covers the longest inhibit used plus a stalling far side
	task automatic get(output can_frame_t f);
		int n;
		n = 0;
		while (m.got.size() == 0 && n < 5000)
		begin
			@(posedge i_clk);
			n++;
		end
		f = '0;
		if (m.got.size() == 0)
			check(64'h0, 64'h1);
		else
			f = m.got.pop_front();
	endtask

	task automatic sdo(input logic [7:0] cmd, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] val, input logic [7:0] ecmd, input logic [31:0] evl);
		can_frame_t f;
		m.send({COB_SDO_RX + 11'(NODE), {val, sub, idx, cmd}});
		get(f);
		check(64'(f.id), 64'(COB_SDO_TX + 11'(NODE)));
		check(f.data, {evl, sub, idx, ecmd});
	endtask

	task automatic trig(input fault_in_t fi, input logic [15:0] x, input logic [15:0] y,
		input logic [15:0] code, input logic [7:0] comm, input logic [7:0] dev,
		input logic [7:0] summ);
		can_frame_t f;
		@(posedge i_clk);
		i_faults <= fi;
		i_angle_x <= x;
		i_angle_y <= y;
		get(f);
		check(64'(f.id), 64'(emcy_base + 11'(NODE)));
		check(f.data, {24'h0, dev, comm, summ, code});
		hist.push_front({comm, dev, code});
		if (hist.size() > 5)
			void'(hist.pop_back());
		sdo(CMD_READ, IDX_FAULT_BITS, SUB_ZERO, 0, CMD_READ_ACK, {16'h0, comm, dev});
		@(posedge i_clk);
		i_faults <= '0;
		i_angle_x <= 16'h0000;
		i_angle_y <= 16'h0000;
		get(f);
		check(f.data, 64'h0);
		@(posedge i_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (60000) @(posedge i_clk);
		fails++;
		finish_test();
	end

	initial
	begin
		i_clk = 1'b0;
		i_rst_n = 1'b0;
		i_faults = '0;
		i_angle_x = 16'h0000;
		i_angle_y = 16'h0000;
		fails = 0;
		checks = 0;
		emcy_base = EMCY_ID_RST[10:0];
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		sdo(CMD_READ, IDX_EMCY_ID, SUB_ZERO, 0, CMD_READ_ACK, EMCY_ID_RST);
		sdo(CMD_READ, IDX_EMCY_INHIBIT, SUB_ZERO, 0, CMD_READ_ACK, 32'h0);
		sdo(CMD_READ, IDX_ERROR_HISTORY, SUB_ZERO, 0, CMD_READ_ACK, 32'h0);
		sdo(CMD_WRITE, IDX_FAULT_BITS, SUB_ZERO, 1, CMD_ABORT, ABORT_RO);
		sdo(CMD_WRITE, 16'h2000, SUB_ZERO, 1, CMD_ABORT, ABORT_NO_OBJ);
		sdo(8'h11, IDX_RANGE, SUB_THR_X, 0, CMD_ABORT, ABORT_COMMAND);
		sdo(CMD_WRITE, IDX_RANGE, 8'h09, 0, CMD_ABORT, ABORT_NO_SUB);
		m.send({COB_SDO_RX + 11'h00b, 64'h0000_0000_0140_0022});
		repeat (6) @(posedge i_clk);
		check(64'(m.got.size()), 64'h0);
		$display("test sdo done");
		// Thresholds are scaled to 0.01 degree: 10 degrees and 1 degree
		sdo(CMD_WRITE, IDX_AXIS_MODE, SUB_ZERO, MODE_TWO_AXIS, CMD_WRITE_ACK, 0);
		sdo(CMD_WRITE, IDX_RANGE, SUB_RANGE_EN, RANGE_EN_ON, CMD_WRITE_ACK, 0);
		sdo(CMD_WRITE, IDX_RANGE, SUB_THR_X, 32'h03e8, CMD_WRITE_ACK, 0);
		sdo(CMD_WRITE, IDX_RANGE, SUB_THR_Y, 32'h0064, CMD_WRITE_ACK, 0);
		@(posedge i_clk);
		i_angle_x <= 16'h03e8;
		repeat (10) @(posedge i_clk);
		check(64'(m.got.size()), 64'h0);
		trig(7'h40, 0, 0, EC_GUARD, 8'h80, 8'h00, 8'h11);
		trig(7'h20, 0, 0, EC_OVERRUN, 8'h04, 8'h00, 8'h11);
		trig(7'h08, 0, 0, EC_WARN, 8'h01, 8'h00, 8'h11);
		trig(7'h04, 0, 0, EC_HW, 8'h00, 8'h80, 8'h81);
		trig(7'h02, 0, 0, EC_HW, 8'h00, 8'h10, 8'h81);
		trig(7'h01, 0, 0, EC_TEMP, 8'h00, 8'h08, 8'h09);
		trig(7'h00, 16'h03e9, 0, EC_AXIS_X, 8'h00, 8'h02, 8'h21);
		trig(7'h00, 0, 16'hff9b, EC_AXIS_Y, 8'h00, 8'h04, 8'h21);
		// Bus-off entry has no code of its own; leaving it is an event, not a reset
		@(posedge i_clk);
		i_faults <= 7'h10;
		get(fr);
		check(fr.data, {24'h0, 8'h00, 8'h02, 8'h11, EC_GENERIC});
		@(posedge i_clk);
		i_faults <= '0;
		get(fr);
		check(fr.data, 64'(EC_BUSOFF_RECOVER));
		hist.push_front({8'h02, 8'h00, EC_GENERIC});
		hist.push_front({16'h0, EC_BUSOFF_RECOVER});
		// Any mode but two-axis leaves the Y limit unchecked
		sdo(CMD_WRITE, IDX_AXIS_MODE, SUB_ZERO, 32'h01, CMD_WRITE_ACK, 0);
		@(posedge i_clk);
		i_angle_y <= 16'hff9b;
		repeat (10) @(posedge i_clk);
		check(64'(m.got.size()), 64'h0);
		i_angle_y <= 16'h0000;
		sdo(CMD_WRITE, IDX_AXIS_MODE, SUB_ZERO, MODE_TWO_AXIS, CMD_WRITE_ACK, 0);
		$display("test fault codes done");
		m.stall <= 1'b1;
		sdo(CMD_WRITE, IDX_EMCY_INHIBIT, SUB_ZERO, 2, CMD_WRITE_ACK, 0);
		trig(7'h01, 0, 0, EC_TEMP, 8'h00, 8'h08, 8'h09);
		check(64'(m.t_last - m.t_prev >= 32'd2000), 64'h1);
		m.stall <= 1'b0;
		sdo(CMD_WRITE, IDX_EMCY_INHIBIT, SUB_ZERO, 0, CMD_WRITE_ACK, 0);
		trig(7'h01, 0, 0, EC_TEMP, 8'h00, 8'h08, 8'h09);
		check(64'(m.t_last - m.t_prev <= 32'd60), 64'h1);
		$display("test inhibit done");
		sdo(CMD_WRITE, IDX_EMCY_ID, SUB_ZERO, 32'h100, CMD_WRITE_ACK, 0);
		emcy_base = 11'h100;
		trig(7'h40, 0, 0, EC_GUARD, 8'h80, 8'h00, 8'h11);
		sdo(CMD_READ, IDX_ERROR_HISTORY, SUB_ZERO, 0, CMD_READ_ACK, 32'h5);
		for (int i = 1; i <= HIST_DEPTH; i++)
			sdo(CMD_READ, IDX_ERROR_HISTORY, 8'(i), 0, CMD_READ_ACK, hist[i - 1]);
		$display("test history done");
		finish_test();
	end
endmodule
`default_nettype wire
